// ---- hdl/pmi_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pmi_map.vh"
module pmi_top #(
   parameter       LANES    = 3,
   parameter [15:0] ID_VALUE = 16'h00a5   // Arbitrary identifier value
) (
   input  wire                REF_CLK_IN,      // 100 MHz clock
   input  wire                SYS_RST_IN,      // Sync reset, high
   input  wire                CLK_EN_IN,       // Freeze when low
   input  wire [LANES*16-1:0] LANE_BITS_IN,    // I/O line levels
   input  wire [5:0]          TIMER_TC_IN,     // Timer terminal counts
   input  wire [3:0]          PROG_CLK_IN,     // Programmable clocks
   input  wire                STROBE_A_IN,     // External strobe a
   input  wire                STROBE_B_IN,     // External strobe b
   input  wire [6:0]          S_AXI_AWADDR_IN, // Write address
   input  wire                S_AXI_AWVALID_IN,// Write address valid
   output reg                 S_AXI_AWREADY_OUT,// Write address ready
   input  wire [31:0]         S_AXI_WDATA_IN,  // Write data
   input  wire [3:0]          S_AXI_WSTRB_IN,  // Write strobes
   input  wire                S_AXI_WVALID_IN, // Write data valid
   output reg                 S_AXI_WREADY_OUT,// Write data ready
   output reg  [1:0]          S_AXI_BRESP_OUT, // Write response
   output reg                 S_AXI_BVALID_OUT,// Write response valid
   input  wire                S_AXI_BREADY_IN, // Write response ready
   input  wire [6:0]          S_AXI_ARADDR_IN, // Read address
   input  wire                S_AXI_ARVALID_IN,// Read address valid
   output reg                 S_AXI_ARREADY_OUT,// Read address ready
   output reg  [31:0]         S_AXI_RDATA_OUT, // Read data
   output reg  [1:0]          S_AXI_RRESP_OUT, // Read response
   output reg                 S_AXI_RVALID_OUT,// Read data valid
   input  wire                S_AXI_RREADY_IN, // Read data ready
   output reg  [1:0]          UNIT_TRIG_OUT,   // Per-unit detection pulses
   output reg                 IRQ_OUT          // Level interrupt
);
   // =======================================================================
   // Input synchronisers: pins pass two flops before any logic
   localparam SW = LANES*16 + 12;
   reg  [SW-1:0]       sync1_q;
   reg  [SW-1:0]       sync2_q;
   wire [LANES*16-1:0] io_s  = sync2_q[LANES*16-1:0];
   wire [5:0]          tc_s  = sync2_q[LANES*16+5:LANES*16];
   wire [3:0]          pc_s  = sync2_q[LANES*16+9:LANES*16+6];
   wire                sa_s  = sync2_q[LANES*16+10];
   wire                sb_s  = sync2_q[LANES*16+11];

   always @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         sync1_q <= {SW{1'b0}};
         sync2_q <= {SW{1'b0}};
      end else if (CLK_EN_IN) begin
         sync1_q <= {STROBE_B_IN, STROBE_A_IN, PROG_CLK_IN, TIMER_TC_IN,
                     LANE_BITS_IN};
         sync2_q <= sync1_q;
      end
   end

   // =======================================================================
   // Base 25 MHz tick derived from the system clock
   localparam [31:0] DIV_FULL = `PMI_BASE_DIV - 1;
   reg  [1:0] div_q;
   wire [1:0] div_last  = DIV_FULL[1:0];  // Cut to the divider width
   wire       base_tick = (div_q == 2'h0);
   always @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN)
         div_q <= 2'h0;
      else if (CLK_EN_IN)
         div_q <= (div_q == div_last) ? 2'h0 : div_q + 2'h1;
   end

   // Source vector indexed by select code; code 1 is reserved, reads low
   wire [15:0] src_vec = {~sb_s, ~sa_s, sb_s, sa_s, pc_s, tc_s,
                          1'b0, base_tick};

   // =======================================================================
   // Configuration registers, one set per unit; interrupt status and mask are one shared set
   reg  [1:0]          kind_q [0:1];
   reg  [3:0]          src_q  [0:1];
   reg  [LANES*16-1:0] ign_q  [0:1];
   reg  [LANES*16-1:0] pat_q  [0:1];
   reg  [1:0]          stat_q;
   reg  [1:0]          imask_q;
   wire [LANES*16-1:0] snap_w [0:1];
   wire [1:0]          hit_w;

   // Both units are identical instances
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_unit
         pmi_unit #(
            .LANES(LANES)
         ) u_unit (
            .clk      (REF_CLK_IN),
            .rst      (SYS_RST_IN),
            .ce       (CLK_EN_IN),
            .io_bits  (io_s),
            .src_vec  (src_vec),
            .base_tick(base_tick),
            .kind     (kind_q[gi]),
            .src_sel  (src_q[gi]),
            .ign      (ign_q[gi]),
            .pat      (pat_q[gi]),
            .snap_q   (snap_w[gi]),
            .hit_q    (hit_w[gi])
         );
      end
   endgenerate

   // =======================================================================
   // Per-lane word offsets, cut to the six offset bits on purpose
   wire [5:0] mask_off [0:LANES-1];
   wire [5:0] pat_off  [0:LANES-1];
   wire [5:0] snap_off [0:LANES-1];
   genvar go;
   generate
      for (go = 0; go < LANES; go = go + 1) begin : g_off
         wire [31:0] m_full = `PMI_A_MASK0 + go * `PMI_A_PORT_STEP;
         wire [31:0] p_full = `PMI_A_PAT0 + go * `PMI_A_PORT_STEP;
         wire [31:0] s_full = `PMI_A_SNAP0 + go * `PMI_A_PORT_STEP;
         assign mask_off[go] = m_full[5:0];
         assign pat_off[go]  = p_full[5:0];
         assign snap_off[go] = s_full[5:0];
      end
   endgenerate

   // =======================================================================
   // AXI4-Lite write path: address and data taken in either order
   reg        aw_have_q;
   reg        w_have_q;
   reg [6:0]  aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   wire       wr_go = aw_have_q & w_have_q & ~S_AXI_BVALID_OUT;
   wire       wr_inst = aw_addr_q[`PMI_INST_BIT];
   wire [5:0] wr_off  = aw_addr_q[5:0];
   wire       wlo = w_strb_q[0];
   wire       whi = w_strb_q[1];
   reg        wr_hit;
   integer    li;   // Loop index of the write decode
   integer    lj;   // Loop index of the register write
   integer    lk;   // Loop index of the read multiplexer

   // Decode a write offset into a hit flag
   always @* begin
      wr_hit = 1'b0;
      if (wr_off == `PMI_A_MODE || wr_off == `PMI_A_SRC ||
          wr_off == `PMI_A_IRQ_STAT || wr_off == `PMI_A_IRQ_MASK)
         wr_hit = 1'b1;
      for (li = 0; li < LANES; li = li + 1) begin
         if (wr_off == mask_off[li] || wr_off == pat_off[li])
            wr_hit = 1'b1;
      end
   end

   // Bus handshake and register writes
   always @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         aw_have_q         <= 1'b0;
         w_have_q          <= 1'b0;
         aw_addr_q         <= 7'h00;
         w_data_q          <= 32'h0000_0000;
         w_strb_q          <= 4'h0;
         S_AXI_AWREADY_OUT <= 1'b0;
         S_AXI_WREADY_OUT  <= 1'b0;
         S_AXI_BVALID_OUT  <= 1'b0;
         S_AXI_BRESP_OUT   <= `PMI_RESP_OKAY;
         kind_q[0] <= `PMI_KIND_OFF;
         kind_q[1] <= `PMI_KIND_OFF;
         src_q[0]  <= `PMI_SRC_BASE;
         src_q[1]  <= `PMI_SRC_BASE;
         ign_q[0]  <= {LANES*16{1'b0}};
         ign_q[1]  <= {LANES*16{1'b0}};
         pat_q[0]  <= {LANES*16{1'b0}};
         pat_q[1]  <= {LANES*16{1'b0}};
         stat_q    <= 2'h0;
         imask_q   <= 2'h0;
      end else if (CLK_EN_IN) begin
         S_AXI_AWREADY_OUT <= ~aw_have_q & ~S_AXI_AWREADY_OUT;
         S_AXI_WREADY_OUT  <= ~w_have_q & ~S_AXI_WREADY_OUT;
         if (S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN & S_AXI_WREADY_OUT) begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA_IN;
            w_strb_q <= S_AXI_WSTRB_IN;
         end
         if (S_AXI_BVALID_OUT & S_AXI_BREADY_IN)
            S_AXI_BVALID_OUT <= 1'b0;
         // Sticky status: a new hit wins over a write-one clear
         stat_q <= stat_q | hit_w;
         if (wr_go) begin
            aw_have_q        <= 1'b0;
            w_have_q         <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= wr_hit ? `PMI_RESP_OKAY : `PMI_RESP_SLVERR;
            if (wr_off == `PMI_A_MODE && wlo)
               kind_q[wr_inst] <= w_data_q[`PMI_MODE_W-1:0];
            if (wr_off == `PMI_A_SRC && wlo)
               src_q[wr_inst] <= w_data_q[`PMI_SRC_W-1:0];
            if (wr_off == `PMI_A_IRQ_STAT && wlo)
               stat_q <= (stat_q & ~w_data_q[1:0]) | hit_w;
            if (wr_off == `PMI_A_IRQ_MASK && wlo)
               imask_q <= w_data_q[1:0];
            for (lj = 0; lj < LANES; lj = lj + 1) begin
               if (wr_off == mask_off[lj]) begin
                  if (wlo) ign_q[wr_inst][lj*16 +: 8] <= w_data_q[7:0];
                  if (whi) ign_q[wr_inst][lj*16+8 +: 8] <= w_data_q[15:8];
               end
               if (wr_off == pat_off[lj]) begin
                  if (wlo) pat_q[wr_inst][lj*16 +: 8] <= w_data_q[7:0];
                  if (whi) pat_q[wr_inst][lj*16+8 +: 8] <= w_data_q[15:8];
               end
            end
         end
      end
   end

   // =======================================================================
   // AXI4-Lite read path: one cycle from address to data
   reg  [15:0] rd_val;
   reg         rd_hit;
   wire        rd_inst = S_AXI_ARADDR_IN[`PMI_INST_BIT];
   wire [5:0]  rd_off  = S_AXI_ARADDR_IN[5:0];

   // Read multiplexer; upper sixteen bits always read as zero
   always @* begin
      rd_val = 16'h0000;
      rd_hit = 1'b1;
      if (rd_off == `PMI_A_ID)
         rd_val = ID_VALUE;
      else if (rd_off == `PMI_A_MODE)
         rd_val = {14'h0000, kind_q[rd_inst]};
      else if (rd_off == `PMI_A_SRC)
         rd_val = {12'h000, src_q[rd_inst]};
      else if (rd_off == `PMI_A_IRQ_STAT)
         rd_val = {14'h0000, stat_q};
      else if (rd_off == `PMI_A_IRQ_MASK)
         rd_val = {14'h0000, imask_q};
      else
         rd_hit = 1'b0;
      for (lk = 0; lk < LANES; lk = lk + 1) begin
         if (rd_off == mask_off[lk]) begin
            rd_val = ign_q[rd_inst][lk*16 +: 16];
            rd_hit = 1'b1;
         end
         if (rd_off == pat_off[lk]) begin
            rd_val = pat_q[rd_inst][lk*16 +: 16];
            rd_hit = 1'b1;
         end
         if (rd_off == snap_off[lk]) begin
            rd_val = snap_w[rd_inst][lk*16 +: 16];
            rd_hit = 1'b1;
         end
      end
   end

   // Read handshake; a new address is taken only once data is gone
   always @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT  <= 1'b0;
         S_AXI_RDATA_OUT   <= 32'h0000_0000;
         S_AXI_RRESP_OUT   <= `PMI_RESP_OKAY;
      end else if (CLK_EN_IN) begin
         S_AXI_ARREADY_OUT <= ~S_AXI_RVALID_OUT & ~S_AXI_ARREADY_OUT &
                              ~S_AXI_ARVALID_IN ? 1'b1 :
                              (~S_AXI_RVALID_OUT & ~S_AXI_ARREADY_OUT);
         if (S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT  <= 1'b1;
            S_AXI_RDATA_OUT   <= {16'h0000, rd_val};
            S_AXI_RRESP_OUT   <= rd_hit ? `PMI_RESP_OKAY : `PMI_RESP_SLVERR;
         end else if (S_AXI_RVALID_OUT & S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
         end
      end
   end

   // =======================================================================
   // Outputs: trigger pulses for clock start/stop, and the level interrupt
   always @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         UNIT_TRIG_OUT <= 2'h0;
         IRQ_OUT       <= 1'b0;
      end else if (CLK_EN_IN) begin
         UNIT_TRIG_OUT <= hit_w;
         IRQ_OUT       <= |((stat_q | hit_w) & imask_q);
      end
   end
endmodule
`default_nettype wire

// ---- hdl/pmi_map.vh ----
`ifndef PMI_MAP_VH
`define PMI_MAP_VH
// ==========================================================================
// Register byte addresses (per instance block, instance 1 adds 0x40)
`define PMI_A_ID          6'h00
`define PMI_A_MODE        6'h04
`define PMI_A_SRC         6'h08
`define PMI_A_MASK0       6'h0c
`define PMI_A_PAT0        6'h18
`define PMI_A_SNAP0       6'h24
`define PMI_A_IRQ_STAT    6'h30
`define PMI_A_IRQ_MASK    6'h34
`define PMI_A_PORT_STEP   4'h4
`define PMI_INST_BIT      6
// ==========================================================================
// Field layout
`define PMI_MODE_W        2
`define PMI_SRC_W         4
`define PMI_LANE_W        16
// ==========================================================================
// Trigger kinds
`define PMI_KIND_OFF      2'h0
`define PMI_KIND_STROBE   2'h1
`define PMI_KIND_MATCH    2'h2
`define PMI_KIND_EVENT    2'h3
// ==========================================================================
// Source select codes
`define PMI_SRC_BASE      4'h0
`define PMI_SRC_TC0       4'h2
`define PMI_SRC_PCLK0     4'h8
`define PMI_SRC_STB_A     4'hc
`define PMI_SRC_STB_B     4'hd
`define PMI_SRC_NSTB_A    4'he
`define PMI_SRC_NSTB_B    4'hf
// ==========================================================================
// Trigger codes offered to the programmable clocks
`define PMI_TRIG_CODE0    5'h10
`define PMI_TRIG_CODE1    5'h11
// ==========================================================================
// Timing: base sampling clock and system clock
`define PMI_BASE_MHZ      25
`define PMI_SYS_MHZ       100
`define PMI_BASE_DIV      (`PMI_SYS_MHZ / `PMI_BASE_MHZ)
// ==========================================================================
// AXI responses
`define PMI_RESP_OKAY     2'h0
`define PMI_RESP_SLVERR   2'h2
`endif

// ---- hdl/pmi_unit.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pmi_map.vh"
// ==========================================================================
// One detection unit: trigger decode, compare, change and snapshot
module pmi_unit #(
   parameter LANES = 3
) (
   input  wire                    clk,          // System clock
   input  wire                    rst,          // Sync reset
   input  wire                    ce,           // Clock enable
   input  wire [LANES*16-1:0]     io_bits,      // Synchronised lines
   input  wire [15:0]             src_vec,      // Synchronised sources
   input  wire                    base_tick,    // 25 MHz sample tick
   input  wire [1:0]              kind,         // Trigger kind
   input  wire [3:0]              src_sel,      // Source select
   input  wire [LANES*16-1:0]     ign,          // Ignore masks
   input  wire [LANES*16-1:0]     pat,          // Match patterns
   output reg  [LANES*16-1:0]     snap_q,       // Snapshot registers
   output reg                     hit_q         // One-cycle detection
);
   reg                src_d1_q;
   reg  [1:0]         kind_q;
   reg  [3:0]         src_sel_q;
   // A kind or source change restarts detection; avoids a false edge
   wire               restart = (kind_q != kind) | (src_sel_q != src_sel);
   wire               src_now = src_vec[src_sel];
   wire               src_rise = src_now & ~src_d1_q;
   wire               sample;
   wire [LANES*16-1:0] mism = (io_bits ^ pat) & ~ign;
   wire [LANES*16-1:0] chg  = (io_bits ^ snap_q) & ~ign;
   reg                fire;

   // Strobe kind and base source sample on the tick; others sample on their rising edge
   assign sample = (kind == `PMI_KIND_STROBE || src_sel == `PMI_SRC_BASE)
                   ? base_tick : src_rise;

   // Trigger decision per kind; all lines whatever their direction
   always @* begin
      fire = 1'b0;
      case (kind)
         `PMI_KIND_MATCH:  fire = sample & ~|mism;
         `PMI_KIND_EVENT:  fire = sample & |chg;
         `PMI_KIND_STROBE: fire = base_tick & src_rise;
         default:          fire = 1'b0;
      endcase
   end

   // Edge memory, snapshot and pulse; a kind change restarts detection
   always @(posedge clk) begin
      if (rst) begin
         src_d1_q <= 1'b0;
         kind_q   <= `PMI_KIND_OFF;
         src_sel_q <= `PMI_SRC_BASE;
         snap_q   <= {LANES*16{1'b0}};
         hit_q    <= 1'b0;
      end else if (ce) begin
         kind_q    <= kind;
         src_sel_q <= src_sel;
         if ((kind == `PMI_KIND_STROBE ? base_tick : 1'b1) | restart)
            src_d1_q <= src_now;
         hit_q <= fire & ~restart;
         if (fire & ~restart)
            snap_q <= io_bits;
      end
   end
endmodule
`default_nettype wire

// ---- dv/pmi_top_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pmi_map.vh"
// ==========================================================================
// Bus and trigger checks on the top ports
module pmi_top_monitor #(
   parameter [15:0] ID_VALUE = 16'h00a5   // Identifier expected on reads
) (
   input wire logic        REF_CLK_IN,         // Clock
   input wire logic        SYS_RST_IN,         // Sync reset
   input wire logic [6:0]  S_AXI_AWADDR_IN,    // Write address
   input wire logic        S_AXI_AWVALID_IN,   // Write address valid
   input wire logic        S_AXI_AWREADY_OUT,  // Write address ready
   input wire logic [1:0]  S_AXI_BRESP_OUT,    // Write response
   input wire logic        S_AXI_BVALID_OUT,   // Write response valid
   input wire logic        S_AXI_BREADY_IN,    // Write response ready
   input wire logic [6:0]  S_AXI_ARADDR_IN,    // Read address
   input wire logic        S_AXI_ARVALID_IN,   // Read address valid
   input wire logic        S_AXI_ARREADY_OUT,  // Read address ready
   input wire logic [31:0] S_AXI_RDATA_OUT,    // Read data
   input wire logic [1:0]  S_AXI_RRESP_OUT,    // Read response
   input wire logic        S_AXI_RVALID_OUT,   // Read data valid
   input wire logic        S_AXI_RREADY_IN,    // Read data ready
   input wire logic [1:0]  UNIT_TRIG_OUT,      // Detection pulses
   input wire logic        IRQ_OUT             // Level interrupt
);
   logic ro_q;   // Accepted write aims at a read-only word
   logic ar_take;

   default clocking mon_cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN);

   assign ar_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;

   // Track the target of the write, so the response can be judged later
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         ro_q <= 1'b0;
      end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
         ro_q <= (S_AXI_AWADDR_IN[5:0] == `PMI_A_ID) ||
                 (S_AXI_AWADDR_IN[5:0] >= `PMI_A_SNAP0 &&
                  S_AXI_AWADDR_IN[5:0] <= 6'h2c);
      end
   end

   // ==========================================================================
   // Assertions
   trig_pulse_zero_a: assert property (UNIT_TRIG_OUT[0] |=> !UNIT_TRIG_OUT[0])
      else $error("unit0 trigger longer than one cycle");
   trig_pulse_one_a: assert property (UNIT_TRIG_OUT[1] |=> !UNIT_TRIG_OUT[1])
      else $error("unit1 trigger longer than one cycle");
   ident_read_a: assert property (ar_take && S_AXI_ARADDR_IN[5:0] == 6'h00
      |=> S_AXI_RVALID_OUT && S_AXI_RDATA_OUT == {16'h0, ID_VALUE})
      else $error("identifier read wrong");
   ro_write_err_a: assert property (S_AXI_BVALID_OUT && ro_q
      |-> S_AXI_BRESP_OUT == `PMI_RESP_SLVERR)
      else $error("read-only write not refused");
   unmapped_read_a: assert property (ar_take &&
      S_AXI_ARADDR_IN[5:0] > `PMI_A_IRQ_MASK |=>
      S_AXI_RRESP_OUT == `PMI_RESP_SLVERR && S_AXI_RDATA_OUT == 32'h0)
      else $error("unmapped read not refused");
   rd_answer_a: assert property (ar_take |=> S_AXI_RVALID_OUT)
      else $error("read answer late");
   rd_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
      S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read data dropped");
   rd_release_a: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN
      |=> !S_AXI_RVALID_OUT)
      else $error("read valid stuck");
   wr_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
      S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
      else $error("write response dropped");

   // Main scenarios reached
   cover property (UNIT_TRIG_OUT[0]);
   cover property (UNIT_TRIG_OUT[1]);
   cover property ($rose(IRQ_OUT));
endmodule

bind pmi_top pmi_top_monitor #(.ID_VALUE(ID_VALUE)) pmi_top_monitor_inst (.*);
`default_nettype wire

// ---- dv/pmi_lines_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Far side: I/O lines, strobes, timer and clock sources
module pmi_lines_model (
   input  wire logic        clk_in,       // Clock
   input  wire logic [47:0] lane_set_in,  // Wanted line levels
   input  wire logic [1:0]  stb_set_in,   // Wanted strobe levels
   output logic      [47:0] lane_out,     // Line levels
   output logic             stb_a_out,    // Strobe a
   output logic             stb_b_out,    // Strobe b
   output logic      [5:0]  tc_out,       // Timer terminal counts
   output logic      [3:0]  pclk_out      // Programmable clocks
);
   logic [4:0] cnt_q = 5'h00;   // Free run, sources never stop

   // Levels change only after an edge, as real pins seen through sync
   always_ff @(posedge clk_in) begin
      cnt_q     <= cnt_q + 5'h01;
      lane_out  <= lane_set_in;
      stb_a_out <= stb_set_in[0];
      stb_b_out <= stb_set_in[1];
   end
   // Timer 0 rises every 32 cycles, clock 0 every 16
   assign tc_out   = {5'h00, cnt_q[4]};
   assign pclk_out = {3'h0, cnt_q[3]};
endmodule
`default_nettype wire

// ---- dv/pmi_top_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pmi_map.vh"
// ==========================================================================
// Register and detection scenarios
module pmi_top_test;
   localparam [15:0] ID = 16'h005a;   // Arbitrary identifier value
   localparam [1:0] OK = `PMI_RESP_OKAY;
   localparam [1:0] ER = `PMI_RESP_SLVERR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [6:0] awaddr = 7'h00, araddr = 7'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [47:0] lanes = 48'h0, lane_w;
   logic [1:0] stb = 2'h0, bresp, rresp, trig;
   logic awready, wready, bvalid, arready, rvalid, irq, sa, sb;
   logic [5:0] tc_w;
   logic [3:0] pclk_w;
   int error_cnt = 0;
   int checks = 0;
   int c, d, k;

   always #5 clk = ~clk;

   pmi_lines_model pmi_lines_model_inst (.clk_in(clk),
      .lane_set_in(lanes), .stb_set_in(stb), .lane_out(lane_w),
      .stb_a_out(sa), .stb_b_out(sb), .tc_out(tc_w), .pclk_out(pclk_w));

   pmi_top #(.LANES(3), .ID_VALUE(ID)) pmi_top_inst (.REF_CLK_IN(clk),
      .SYS_RST_IN(rst), .CLK_EN_IN(1'b1), .LANE_BITS_IN(lane_w),
      .TIMER_TC_IN(tc_w), .PROG_CLK_IN(pclk_w), .STROBE_A_IN(sa),
      .STROBE_B_IN(sb), .S_AXI_AWADDR_IN(awaddr),
      .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf),
      .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
      .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
      .UNIT_TRIG_OUT(trig), .IRQ_OUT(irq));

   task stop_test;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bus write; address and data released each as soon as it is taken
   task wr(input logic u, input logic [5:0] o, input logic [31:0] v,
           input logic [1:0] er);
      int i;
      @(posedge clk);
      awaddr <= {u, o};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (i == 50) begin
         error_cnt++;
         stop_test;
      end
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task rd(input logic u, input logic [5:0] o, input logic [31:0] v,
           input logic [1:0] er);
      int i;
      @(posedge clk);
      araddr <= {u, o};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (i == 50) begin
         error_cnt++;
         stop_test;
      end
      chk(rdata, v);
      chk({30'h0, rresp}, {30'h0, er});
   endtask

   // Count detection pulses of one unit over n cycles
   task cnt(input int u, input int n, output int r);
      r = 0;
      repeat (n) begin
         @(posedge clk);
         if (trig[u] === 1'b1) r++;
      end
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // Identifier and reset values of both units
      for (k = 0; k < 2; k++) begin
         rd(k[0], `PMI_A_ID, {16'h0, ID}, OK);
         rd(k[0], `PMI_A_MODE, 32'h0, OK);
         rd(k[0], `PMI_A_SRC, 32'h0, OK);
         for (c = 0; c < 3; c++) begin
            rd(k[0], `PMI_A_MASK0 + 6'(4 * c), 32'h0, OK);
            rd(k[0], `PMI_A_PAT0 + 6'(4 * c), 32'h0, OK);
            rd(k[0], `PMI_A_SNAP0 + 6'(4 * c), 32'h0, OK);
         end
      end
      // Upper half of a 32-bit write is dropped; refusals
      wr(1, `PMI_A_MASK0 + 6'h04, 32'hdead1234, OK);
      rd(1, `PMI_A_MASK0 + 6'h04, 32'h1234, OK);
      wr(1, `PMI_A_PAT0 + 6'h08, 32'h0000c3c3, OK);
      rd(1, `PMI_A_PAT0 + 6'h08, 32'h0000c3c3, OK);
      wr(0, `PMI_A_ID, 32'h1, ER);
      wr(0, `PMI_A_SNAP0, 32'h1, ER);
      rd(0, 6'h38, 32'h0, ER);
      wr(0, `PMI_A_IRQ_MASK, 32'h3, OK);
      // Match on lane 0 low byte only; one wrong bit must not fire
      wr(0, `PMI_A_MASK0, 32'hff00, OK);
      wr(0, `PMI_A_MASK0 + 6'h04, 32'hffff, OK);
      wr(0, `PMI_A_MASK0 + 6'h08, 32'hffff, OK);
      wr(0, `PMI_A_PAT0, 32'h00a5, OK);
      lanes <= 48'h0f0f_beef_37a4;
      wr(0, `PMI_A_MODE, {30'h0, `PMI_KIND_MATCH}, OK);
      cnt(0, 40, c);
      chk(c, 0);
      lanes <= 48'h0f0f_beef_37a5;
      cnt(0, 40, c);
      chk({31'h0, c > 0}, 1);
      chk({31'h0, irq}, 1);
      wr(0, `PMI_A_MODE, {30'h0, `PMI_KIND_OFF}, OK);
      rd(0, `PMI_A_SNAP0, 32'h37a5, OK);
      rd(0, `PMI_A_SNAP0 + 6'h04, 32'hbeef, OK);
      wr(0, `PMI_A_IRQ_STAT, 32'h1, OK);
      cnt(0, 3, c);
      chk({31'h0, irq}, 0);
      // Everything masked: fires at once on the base clock
      wr(0, `PMI_A_MASK0, 32'hffff, OK);
      wr(0, `PMI_A_MODE, {30'h0, `PMI_KIND_MATCH}, OK);
      cnt(0, 12, c);
      chk({31'h0, c > 0}, 1);
      // Reserved source never samples; timer 0 samples on its rising edges
      wr(0, `PMI_A_SRC, 32'h1, OK);
      cnt(0, 8, c);
      cnt(0, 100, c);
      chk(c, 0);
      wr(0, `PMI_A_SRC, {28'h0, `PMI_SRC_TC0}, OK);
      cnt(0, 100, c);
      chk({31'h0, c >= 3 && c <= 4}, 1);
      wr(0, `PMI_A_MODE, {30'h0, `PMI_KIND_OFF}, OK);
      // Event on unit 1: lane 2 ignored, each change fires once
      wr(1, `PMI_A_MASK0 + 6'h04, 32'h0, OK);
      wr(1, `PMI_A_MASK0 + 6'h08, 32'hffff, OK);
      wr(1, `PMI_A_MODE, {30'h0, `PMI_KIND_EVENT}, OK);
      cnt(1, 30, c);
      cnt(1, 40, c);
      chk(c, 0);
      lanes[47] <= ~lanes[47];
      cnt(1, 40, c);
      chk(c, 0);
      for (k = 0; k < 2; k++) begin
         lanes[16] <= ~lanes[16];
         cnt(1, 40, c);
         chk(c, 1);
      end
      rd(1, `PMI_A_SNAP0 + 6'h04, {16'h0, lanes[31:16]}, OK);
      rd(1, `PMI_A_SNAP0 + 6'h08, {16'h0, lanes[47:32]}, OK);
      chk({31'h0, irq}, 1);
      // Masking hides the pending bit; clearing removes it
      wr(0, `PMI_A_IRQ_MASK, 32'h0, OK);
      cnt(1, 3, c);
      chk({31'h0, irq}, 0);
      wr(0, `PMI_A_IRQ_STAT, 32'h3, OK);
      wr(0, `PMI_A_IRQ_MASK, 32'h3, OK);
      cnt(1, 3, c);
      chk({31'h0, irq}, 0);
      wr(1, `PMI_A_MODE, {30'h0, `PMI_KIND_OFF}, OK);
      // Strobe kind through all four strobe codes, one pulse each
      wr(0, `PMI_A_MODE, {30'h0, `PMI_KIND_STROBE}, OK);
      for (k = 0; k < 4; k++) begin
         wr(0, `PMI_A_SRC, {28'h0, `PMI_SRC_STB_A + 4'(k)}, OK);
         cnt(0, 20, c);
         stb[k % 2] <= 1'b1;
         cnt(0, 12, c);
         stb[k % 2] <= 1'b0;
         cnt(0, 40, d);
         chk(c + d, 1);
      end
      stop_test;
   end
endmodule
`default_nettype wire
